// ---- rtl/strlfo_map.vh ----
// Purpose: register map, field positions, reset values and fixed-point constants of the stereo tremolo block
// Assumes: included by bare name from every design file
// Notes: definitions only
`ifndef STRLFO_MAP_VH
`define STRLFO_MAP_VH
// register byte offsets
`define STRLFO_OFS_CTRL 8'h00
`define STRLFO_OFS_RATE 8'h04
`define STRLFO_OFS_MULT 8'h08
`define STRLFO_OFS_TEMPO 8'h0c
`define STRLFO_OFS_DEPTH 8'h10
`define STRLFO_OFS_DUTY 8'h14
`define STRLFO_OFS_BEND 8'h18
`define STRLFO_OFS_PHOFS 8'h1c
`define STRLFO_OFS_LEVEL 8'h20
`define STRLFO_OFS_STAT 8'h24
`define STRLFO_OFS_PHASE 8'h28
// control fields
`define STRLFO_B_ACTIVE 0
`define STRLFO_B_SYNC 1
`define STRLFO_B_EXT 2
`define STRLFO_B_INV 3
`define STRLFO_F_WAVE 6:4
`define STRLFO_B_MUTE 16
// waveform codes
`define STRLFO_W_SINE 3'h0
`define STRLFO_W_RISE 3'h1
`define STRLFO_W_FALL 3'h2
`define STRLFO_W_PULSE 3'h3
`define STRLFO_W_TRI 3'h4
`define STRLFO_W_EXP 3'h5
// reset values
`define STRLFO_RST_CTRL 7'h41
`define STRLFO_RST_RATE 11'h064
`define STRLFO_RST_MULT 15'h0001
`define STRLFO_RST_TEMPO 8'h78
`define STRLFO_RST_DEPTH 7'h64
`define STRLFO_RST_DUTY 7'h32
`define STRLFO_RST_BEND 7'h00
`define STRLFO_RST_PHOFS 12'h000
`define STRLFO_RST_LEVEL 11'h000
// limits (hundredths of hertz or of x, percent, tenths of degree or dB)
`define STRLFO_RATE_FREE_MAX 11'h3e8
`define STRLFO_RATE_SYNC_MAX 11'h4b0
`define STRLFO_MULT_MIN 15'h0001
`define STRLFO_MULT_MAX 15'h6200
`define STRLFO_PCT_MAX 7'h64
`define STRLFO_PHOFS_MAX 12'he10
`define STRLFO_BEND_MIN 7'sh44
`define STRLFO_BEND_MAX 7'sh1e
`define STRLFO_LEVEL_MIN 11'sh4ea
`define STRLFO_LEVEL_MAX 11'sh0f0
// arithmetic constants
`define STRLFO_CENTI 64'h64
`define STRLFO_CENTI_MIN 64'h1770
`define STRLFO_Q12_ONE 13'h1000
`define STRLFO_Q12 12
`define STRLFO_LFO_MAX 16'hffff
`define STRLFO_PCT_Q12 16'ha3d7
`define STRLFO_PCT_Q16 17'h290
`define STRLFO_DEG_STEP 32'h00123456
`define STRLFO_BEND_NEG_K 8'h44
`define STRLFO_BEND_POS_K 8'h71
`define STRLFO_DB_OFS 12'h348
`define STRLFO_DB_STEP 12'h03c
`define STRLFO_DB_BIAS 14
`define STRLFO_TENTHS 12'h00a
`endif

// ---- rtl/strlfo_wave.v ----
// Purpose: oscillator shape generator, phase in, level out (0 deepest, all ones unity)
// Assumes: purely combinational, fed from registered phase
// Notes: sine is a smoothstep of the triangle, exponential is the falling ramp to the fourth power
`include "strlfo_map.vh"
`timescale 1ns/100ps
module strlfo_wave (
   input wire [15:0] phase_in,
   input wire [2:0] shape_in,
   input wire [6:0] duty_in,
   output reg [15:0] level_out
);
   reg [15:0] tri_w;
   reg [31:0] t2;
   reg [31:0] t3;
   reg [31:0] smooth;
   reg [31:0] e2;
   reg [31:0] e4;
   reg [16:0] edge_w;
   reg [15:0] inv_w;

   // every shape is built each cycle, the selector picks one
   always @* begin
      tri_w = phase_in[15] ? ~{phase_in[14:0], 1'b0} : {phase_in[14:0], 1'b0};
      t2 = (tri_w * tri_w) >> 16;
      t3 = (t2 * tri_w) >> 16;
      smooth = 32'h3 * t2 - 32'h2 * t3; // rounded stand-in for a sine, avoids a table
      inv_w = ~phase_in; // inverted at 16 bits, a wider context would invert the padding too
      e2 = (inv_w * inv_w) >> 16;
      e4 = (e2 * e2) >> 16;
      edge_w = duty_in * `STRLFO_PCT_Q16;
      case (shape_in)
         `STRLFO_W_SINE: level_out = (smooth > 32'hffff) ? `STRLFO_LFO_MAX : smooth[15:0];
         `STRLFO_W_RISE: level_out = phase_in;
         `STRLFO_W_FALL: level_out = ~phase_in;
         `STRLFO_W_PULSE: level_out = ({1'b0, phase_in} < edge_w) ? `STRLFO_LFO_MAX : 16'h0000;
         `STRLFO_W_TRI: level_out = tri_w;
         `STRLFO_W_EXP: level_out = e4[15:0];
         default: level_out = tri_w;
      endcase
   end
endmodule

// ---- rtl/strlfo_core.v ----
// Purpose: stereo tremolo / auto-balance processor with APB register access
// Assumes: one sample pair per sample_valid_in pulse, inputs synchronous to ref_clk_in
// Notes: output pair appears one clock after the input pulse; APB access phase takes two cycles
// Functional notes
// - when the active bit is set the tremolo is applied, otherwise input passes through unchanged.
// - the processed output is scaled by the output level, muted or -79.0 to +24.0 dB.
// - attenuation at the deepest oscillator point follows depth, 0 to 100 percent.
// - six oscillator shapes are offered: sine, rising ramp, falling ramp, pulse, up-down and exponential.
// - with the pulse shape the duty sets the high fraction of each period, other shapes ignore it.
// - the midpoint bend warps the curve around its -6 dB point toward unity or full attenuation.
// - with left inversion the left channel uses an inverted copy of the oscillator.
// - in free mode the oscillator rate is modulation_rate, 0 to 10.00 Hz.
// - in free mode the rate multiplier, 1 to 25088, multiplies modulation_rate.
// - in synced mode the tempo is 0 to 255 BPM or follows the external tempo source.
// - while external sync is selected the local tempo setting has no effect.
// - in synced mode modulation_rate counts oscillator cycles per beat, 0 to 12.00.
// - in synced mode the phase offset shifts the oscillator against the beat reference, 0 to 360.0 degrees.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`include "strlfo_map.vh"
`timescale 1ns/100ps
module strlfo_core #(
   parameter SAMPLE_W = 24,
   parameter SAMPLE_HZ = 24000
) (
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   output wire [31:0] prdata_out,
   output wire pready_out,
   output wire pslverr_out,
   input wire sample_valid_in,
   input wire signed [SAMPLE_W-1:0] left_in,
   input wire signed [SAMPLE_W-1:0] right_in,
   input wire [7:0] ext_tempo_in,
   input wire beat_pulse_in,
   output wire sample_valid_out,
   output wire signed [SAMPLE_W-1:0] left_out,
   output wire signed [SAMPLE_W-1:0] right_out
);
   localparam [63:0] K_FREE = (64'h1 << 48) / (`STRLFO_CENTI * SAMPLE_HZ);
   localparam [63:0] K_SYNC = (64'h1 << 48) / (`STRLFO_CENTI_MIN * SAMPLE_HZ);

   // clamp an unsigned setting into its legal range
   function [31:0] clampu;
      input [31:0] v;
      input [31:0] lo;
      input [31:0] hi;
      begin
         clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   // gain per dB step inside one 6 dB octave, Q12
   function [12:0] mant;
      input [3:0] d;
      begin
         case (d)
            4'h0: mant = 13'h1000;
            4'h1: mant = 13'h11f6;
            4'h2: mant = 13'h1429;
            4'h3: mant = 13'h16a1;
            4'h4: mant = 13'h1966;
            4'h5: mant = 13'h1c82;
            default: mant = 13'h1fff;
         endcase
      end
   endfunction

   // tenths of dB to linear Q12; a 6 dB step is taken as an exact doubling
   function [17:0] db_to_lin;
      input signed [10:0] t;
      reg [11:0] u;
      reg [11:0] r;
      reg [11:0] q;
      reg [11:0] rd;
      reg [12:0] m0;
      reg [12:0] m1;
      reg [31:0] m;
      begin
         u = $unsigned({t[10], t}) + `STRLFO_DB_OFS;
         q = u / `STRLFO_DB_STEP;
         r = u % `STRLFO_DB_STEP;
         rd = r / `STRLFO_TENTHS;
         m0 = mant(rd[3:0]);
         m1 = mant(rd[3:0] + 4'h1);
         m = m0 + ((m1 - m0) * (r % `STRLFO_TENTHS)) / `STRLFO_TENTHS;
         m = (m << q) >> `STRLFO_DB_BIAS;
         db_to_lin = m[17:0];
      end
   endfunction

   // bend around the half-level point, then depth, giving a Q12 channel gain
   function [12:0] chan_gain;
      input [15:0] x;
      input signed [6:0] bend;
      input [6:0] depth;
      reg signed [35:0] k;
      reg signed [35:0] b;
      reg [31:0] dq;
      reg [31:0] att;
      reg [31:0] xx;
      begin
         k = bend[6] ? bend * $signed({1'b0, `STRLFO_BEND_NEG_K}) : bend * $signed({1'b0, `STRLFO_BEND_POS_K});
         xx = x * (`STRLFO_LFO_MAX - x); // product kept at full width before taking its top half
         b = $signed({20'h0, x}) + ((k * $signed({20'h0, xx[31:16]})) >>> `STRLFO_Q12);
         if (b < 0)
            b = 36'sh0;
         if (b > $signed({20'h0, `STRLFO_LFO_MAX}))
            b = $signed({20'h0, `STRLFO_LFO_MAX});
         dq = (depth * `STRLFO_Q12_ONE) / `STRLFO_PCT_MAX;
         // full scale is one step past the top level, so full depth reaches silence
         att = (dq * ({16'h0, `STRLFO_LFO_MAX} + 32'h1 - {16'h0, b[15:0]})) >> 16;
         chan_gain = `STRLFO_Q12_ONE - att[12:0];
      end
   endfunction

   // two gains in turn, then saturation to the sample width
   function [SAMPLE_W-1:0] scale;
      input signed [SAMPLE_W-1:0] s;
      input [12:0] gm;
      input [17:0] gl;
      reg signed [47:0] p;
      begin
         p = s * $signed({1'b0, gm});
         p = p >>> `STRLFO_Q12;
         p = p * $signed({1'b0, gl});
         p = p >>> `STRLFO_Q12;
         if ((&p[47:SAMPLE_W-1]) | ~(|p[47:SAMPLE_W-1]))
            scale = p[SAMPLE_W-1:0];
         else
            scale = p[47] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
      end
   endfunction

   reg [6:0] ctrl_q;
   reg [10:0] rate_q;
   reg [14:0] mult_q;
   reg [7:0] tempo_q;
   reg [6:0] depth_q;
   reg [6:0] duty_q;
   reg signed [6:0] bend_q;
   reg [11:0] phofs_q;
   reg signed [10:0] level_q;
   reg mute_q;
   reg [17:0] lvl_lin_q;
   reg [31:0] inc_q;
   reg [31:0] acc_q;
   reg pready_q;
   reg pslverr_q;
   reg [31:0] prdata_q;
   reg valid_q;
   reg signed [SAMPLE_W-1:0] left_q;
   reg signed [SAMPLE_W-1:0] right_q;
   reg [31:0] rd_d;
   reg hit_d;
   reg [31:0] rate_lim;
   reg [31:0] mult_lim;
   reg [31:0] depth_lim;
   reg [31:0] duty_lim;
   reg [31:0] phofs_lim;

   wire wr_done = psel_in & penable_in & pready_q & pwrite_in;
   wire sync_mode = ctrl_q[`STRLFO_B_SYNC];
   wire [7:0] bpm = ctrl_q[`STRLFO_B_EXT] ? ext_tempo_in : tempo_q;
   wire [10:0] rate_free = (rate_q > `STRLFO_RATE_FREE_MAX) ? `STRLFO_RATE_FREE_MAX : rate_q;
   wire [63:0] prod_free = rate_free * mult_q * K_FREE;
   wire [63:0] prod_sync = bpm * rate_q * K_SYNC;
   wire [31:0] ph_shift = sync_mode ? phofs_q * `STRLFO_DEG_STEP : 32'h0;
   wire [31:0] phase_now = acc_q + ph_shift;
   wire [15:0] lfo;
   wire [15:0] lfo_l = ctrl_q[`STRLFO_B_INV] ? ~lfo : lfo;
   wire [12:0] gain_l = chan_gain(lfo_l, bend_q, depth_q);
   wire [12:0] gain_r = chan_gain(lfo, bend_q, depth_q);

   // oscillator shape from the current phase
   strlfo_wave u_wave (
      .phase_in(phase_now[31:16]),
      .shape_in(ctrl_q[`STRLFO_F_WAVE]),
      .duty_in(duty_q),
      .level_out(lfo)
   );

   // read decode; unmapped offsets answer with an error
   always @* begin
      rd_d = 32'h0;
      hit_d = 1'b1;
      case (paddr_in)
         `STRLFO_OFS_CTRL: rd_d = {25'h0, ctrl_q};
         `STRLFO_OFS_RATE: rd_d = {21'h0, rate_q};
         `STRLFO_OFS_MULT: rd_d = {17'h0, mult_q};
         `STRLFO_OFS_TEMPO: rd_d = {24'h0, tempo_q};
         `STRLFO_OFS_DEPTH: rd_d = {25'h0, depth_q};
         `STRLFO_OFS_DUTY: rd_d = {25'h0, duty_q};
         `STRLFO_OFS_BEND: rd_d = {{25{bend_q[6]}}, bend_q};
         `STRLFO_OFS_PHOFS: rd_d = {20'h0, phofs_q};
         `STRLFO_OFS_LEVEL: rd_d = {15'h0, mute_q, {5{level_q[10]}}, level_q};
         `STRLFO_OFS_STAT: rd_d = {lfo, 3'h0, gain_r};
         `STRLFO_OFS_PHASE: rd_d = acc_q;
         default: hit_d = 1'b0;
      endcase
   end

   // apb slave: one wait state, answer captured in the first access cycle
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= psel_in & penable_in & ~pready_q;
         if (psel_in & penable_in & ~pready_q) begin
            pslverr_q <= ~hit_d;
            prdata_q <= pwrite_in ? 32'h0 : rd_d;
         end else begin
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
         end
      end
   end

   // clamped write values, each sliced to its field width below
   always @* begin
      rate_lim = clampu(pwdata_in, 32'h0, {21'h0, `STRLFO_RATE_SYNC_MAX});
      mult_lim = clampu(pwdata_in, {17'h0, `STRLFO_MULT_MIN}, {17'h0, `STRLFO_MULT_MAX});
      depth_lim = clampu(pwdata_in, 32'h0, {25'h0, `STRLFO_PCT_MAX});
      duty_lim = clampu(pwdata_in, 32'h0, {25'h0, `STRLFO_PCT_MAX});
      phofs_lim = clampu(pwdata_in, 32'h0, {20'h0, `STRLFO_PHOFS_MAX});
   end

   // settings, clamped to their legal ranges as they are written
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_q <= `STRLFO_RST_CTRL;
         rate_q <= `STRLFO_RST_RATE;
         mult_q <= `STRLFO_RST_MULT;
         tempo_q <= `STRLFO_RST_TEMPO;
         depth_q <= `STRLFO_RST_DEPTH;
         duty_q <= `STRLFO_RST_DUTY;
         bend_q <= `STRLFO_RST_BEND;
         phofs_q <= `STRLFO_RST_PHOFS;
         level_q <= `STRLFO_RST_LEVEL;
         mute_q <= 1'b0;
      end else if (wr_done) begin
         case (paddr_in)
            `STRLFO_OFS_CTRL: ctrl_q <= pwdata_in[6:0];
            `STRLFO_OFS_RATE: rate_q <= rate_lim[10:0];
            `STRLFO_OFS_MULT: mult_q <= mult_lim[14:0];
            `STRLFO_OFS_TEMPO: tempo_q <= pwdata_in[7:0];
            `STRLFO_OFS_DEPTH: depth_q <= depth_lim[6:0];
            `STRLFO_OFS_DUTY: duty_q <= duty_lim[6:0];
            `STRLFO_OFS_BEND: begin
               if ($signed(pwdata_in) < $signed({{25{1'b1}}, `STRLFO_BEND_MIN}))
                  bend_q <= `STRLFO_BEND_MIN;
               else if ($signed(pwdata_in) > $signed({25'h0, `STRLFO_BEND_MAX}))
                  bend_q <= `STRLFO_BEND_MAX;
               else
                  bend_q <= pwdata_in[6:0];
            end
            `STRLFO_OFS_PHOFS: phofs_q <= phofs_lim[11:0];
            `STRLFO_OFS_LEVEL: begin
               mute_q <= pwdata_in[`STRLFO_B_MUTE];
               if ($signed(pwdata_in[15:0]) < $signed({{5{1'b1}}, `STRLFO_LEVEL_MIN}))
                  level_q <= `STRLFO_LEVEL_MIN;
               else if ($signed(pwdata_in[15:0]) > $signed({5'h0, `STRLFO_LEVEL_MAX}))
                  level_q <= `STRLFO_LEVEL_MAX;
               else
                  level_q <= pwdata_in[10:0];
            end
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // derived values are registered so the multipliers stay off the sample path
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lvl_lin_q <= 18'h0;
         inc_q <= 32'h0;
      end else begin
         lvl_lin_q <= mute_q ? 18'h0 : db_to_lin(level_q);
         inc_q <= sync_mode ? prod_sync[47:16] : prod_free[47:16];
      end
   end

   // phase steps once per sample pair; a beat pulse realigns it in synced mode
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         acc_q <= 32'h0;
      else if (sync_mode & beat_pulse_in)
         acc_q <= 32'h0;
      else if (sample_valid_in)
         acc_q <= acc_q + inc_q;
   end

   // sample path; no holding buffer, the sink must take each pair at once
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         valid_q <= 1'b0;
         left_q <= {SAMPLE_W{1'b0}};
         right_q <= {SAMPLE_W{1'b0}};
      end else begin
         valid_q <= sample_valid_in;
         if (sample_valid_in) begin
            if (ctrl_q[`STRLFO_B_ACTIVE]) begin
               left_q <= scale(left_in, gain_l, lvl_lin_q);
               right_q <= scale(right_in, gain_r, lvl_lin_q);
            end else begin
               left_q <= left_in;
               right_q <= right_in;
            end
         end
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign sample_valid_out = valid_q;
   assign left_out = left_q;
   assign right_out = right_q;
endmodule

// ---- sim/strlfo_asserts.sv ----
// Purpose: port-level checks of the stereo tremolo core
// Assumes: sees only the core's ports, attached by bind
// Notes: the active bit is shadowed from observed control writes
`timescale 1ns/100ps
module strlfo_chk #(parameter SAMPLE_W = 24) (
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire [31:0] prdata_out,
   input wire pready_out,
   input wire pslverr_out,
   input wire sample_valid_in,
   input wire signed [SAMPLE_W-1:0] left_in,
   input wire signed [SAMPLE_W-1:0] right_in,
   input wire sample_valid_out,
   input wire signed [SAMPLE_W-1:0] left_out,
   input wire signed [SAMPLE_W-1:0] right_out
);
   reg [2:0] act_q;
   // two of the three stages, act_q[1:0], cover the settle time of a new setting
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) act_q <= 3'h7;
      else if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h00) act_q <= {act_q[1:0], pwdata_in[0]};
      else act_q <= {act_q[1:0], act_q[0]};
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   a_ready_one_wait: assert property (psel_in && !penable_in ##1 psel_in && penable_in |-> !pready_out ##1 pready_out)
      else $error("ready not on second access cycle");
   a_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("ready longer than one cycle");
   a_err_in_access: assert property (pslverr_out |-> pready_out && psel_in && penable_in)
      else $error("slave error outside an answer");
   a_err_unmapped: assert property (pready_out |-> pslverr_out == (paddr_in > 8'h28 || paddr_in[1:0] != 2'h0))
      else $error("slave error does not match address");
   a_rdata_idle: assert property (!(pready_out && !pwrite_in) |-> prdata_out == 32'h0)
      else $error("read data outside a read answer");
   a_valid_next: assert property (sample_valid_in |=> sample_valid_out)
      else $error("pair not answered next cycle");
   a_valid_cause: assert property (sample_valid_out |-> $past(sample_valid_in))
      else $error("output pulse without input pair");
   a_pair_hold: assert property (!sample_valid_out |-> $stable(left_out) && $stable(right_out))
      else $error("output pair changed between pulses");
   a_bypass_copy: assert property (sample_valid_in && act_q[1:0] == 2'h0 |=> left_out == $past(left_in) && right_out == $past(right_in))
      else $error("bypass output differs from input");
   c_err: cover property (pready_out && pslverr_out);
   c_read: cover property (pready_out && !pwrite_in);
   c_bypass: cover property (sample_valid_out && act_q[1:0] == 2'h0);
endmodule
bind strlfo_core strlfo_chk #(.SAMPLE_W(SAMPLE_W)) strlfo_chk_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .sample_valid_in(sample_valid_in),
   .left_in(left_in), .right_in(right_in), .sample_valid_out(sample_valid_out), .left_out(left_out),
   .right_out(right_out));

// ---- sim/strlfo_src.sv ----
// Purpose: upstream sample source and downstream sink around the core
// Assumes: one stereo pair per send call
// Notes: between pulses the data lines carry the inverse of the last pair
`timescale 1ns/100ps
module strlfo_src #(parameter SAMPLE_W = 24) (
   input wire ref_clk_in,
   input wire sample_valid_out,
   input wire signed [SAMPLE_W-1:0] left_out,
   input wire signed [SAMPLE_W-1:0] right_out,
   output logic sample_valid_in,
   output logic signed [SAMPLE_W-1:0] left_in,
   output logic signed [SAMPLE_W-1:0] right_in
);
   logic signed [SAMPLE_W-1:0] got_l;
   logic signed [SAMPLE_W-1:0] got_r;
   // idle source at time zero
   initial begin
      sample_valid_in = 1'b0;
      left_in = '0;
      right_in = '0;
   end
   // sink takes every pair, it cannot stall the core
   always @(posedge ref_clk_in) begin
      if (sample_valid_out) begin
         got_l <= left_out;
         got_r <= right_out;
      end
   end
   // one pair per pulse; scrambled data afterwards catches late sampling
   task automatic send(input logic signed [SAMPLE_W-1:0] l, input logic signed [SAMPLE_W-1:0] r);
      @(posedge ref_clk_in);
      sample_valid_in <= 1'b1;
      left_in <= l;
      right_in <= r;
      @(posedge ref_clk_in);
      sample_valid_in <= 1'b0;
      left_in <= ~l;
      right_in <= ~r;
      repeat (2) @(posedge ref_clk_in);
   endtask
endmodule

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the stereo tremolo core
// Assumes: APB master and samples driven just after rising edges
// Notes: rate checks compare accumulator steps over four pairs
`timescale 1ns/100ps
`include "strlfo_map.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module testbench;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, beat_pulse_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [7:0] ext_tempo_in = 8'h78;
   logic [31:0] pwdata_in = 32'h0;
   wire [31:0] prdata_out;
   wire pready_out, pslverr_out, sample_valid_in, sample_valid_out;
   wire signed [23:0] left_in, right_in, left_out, right_out;
   int num_errors = 0;
   int checks = 0;
   logic [31:0] q, d1, d2;
   logic e;
   always #2 ref_clk_in = ~ref_clk_in;
   strlfo_core strlfo_core_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .sample_valid_in(sample_valid_in), .left_in(left_in),
      .right_in(right_in), .ext_tempo_in(ext_tempo_in), .beat_pulse_in(beat_pulse_in),
      .sample_valid_out(sample_valid_out), .left_out(left_out), .right_out(right_out));
   strlfo_src strlfo_src_i (.ref_clk_in(ref_clk_in), .sample_valid_out(sample_valid_out), .left_out(left_out),
      .right_out(right_out), .sample_valid_in(sample_valid_in), .left_in(left_in), .right_in(right_in));
   // one APB transfer; answer taken at the edge that sees pready high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
      @(posedge ref_clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= dat;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      // no cycle count is assumed; only the watchdog ends a hung wait
      do begin
         @(posedge ref_clk_in);
      end while (pready_out !== 1'b1);
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   // accumulator advance over four pairs
   task delta(output logic [31:0] dd);
      logic [31:0] p;
      apb(0, `STRLFO_OFS_PHASE, 0);
      p = q;
      repeat (4) strlfo_src_i.send(24'sh100000, 24'sh100000);
      apb(0, `STRLFO_OFS_PHASE, 0);
      dd = q - p;
   endtask
   // beat pulse parks the phase at zero, then one pair shows the gain there
   task deep(input logic [31:0] c, input logic zl, input logic zr);
      apb(1, `STRLFO_OFS_CTRL, c);
      beat_pulse_in <= 1'b1;
      @(posedge ref_clk_in);
      beat_pulse_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      strlfo_src_i.send(24'sh100000, 24'sh100000);
      `CHK(strlfo_src_i.got_l == 0, zl)
      `CHK(strlfo_src_i.got_r == 0, zr)
   endtask
   task t_regs;
      logic [7:0] ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
      logic [31:0] rv [9] = '{32'h41, 32'h64, 32'h1, 32'h78, 32'h64, 32'h32, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 9; i++) begin
         apb(0, ofs[i], 0);
         `CHK(q, rv[i])
      end
      apb(1, 8'h40, 32'h5);
      `CHK(e, 1'b1)
      apb(0, 8'h40, 0);
      `CHK({e, q}, 33'h100000000)
      $display("test regs done");
   endtask
   task t_level;
      apb(1, `STRLFO_OFS_DEPTH, 0);
      apb(1, `STRLFO_OFS_LEVEL, 32'h3c);
      strlfo_src_i.send(24'sh0003e8, -24'sh0003e8);
      `CHK(strlfo_src_i.got_l, 24'sh0007d0)
      `CHK(strlfo_src_i.got_r, -24'sh0007d0)
      apb(1, `STRLFO_OFS_CTRL, 32'h40);
      strlfo_src_i.send(24'sh0003e8, -24'sh0003e8);
      `CHK(strlfo_src_i.got_l, 24'sh0003e8)
      apb(1, `STRLFO_OFS_CTRL, 32'h41);
      apb(1, `STRLFO_OFS_LEVEL, 32'h10000);
      strlfo_src_i.send(24'sh0003e8, 24'sh0003e8);
      `CHK(strlfo_src_i.got_r, 24'sh000000)
      apb(1, `STRLFO_OFS_LEVEL, 32'h0);
      strlfo_src_i.send(24'sh0003e8, 24'sh0003e8);
      `CHK(strlfo_src_i.got_r, 24'sh0003e8)
      $display("test level done");
   endtask
   task t_deep;
      apb(1, `STRLFO_OFS_DEPTH, 32'h64);
      deep(32'h13, 1, 1);
      deep(32'h1b, 0, 1);
      deep(32'h23, 0, 0);
      apb(1, `STRLFO_OFS_DUTY, 0);
      deep(32'h33, 1, 1);
      deep(32'h23, 0, 0);
      apb(1, `STRLFO_OFS_DUTY, 32'h64);
      deep(32'h33, 0, 0);
      deep(32'h03, 1, 1);
      deep(32'h53, 0, 0);
      deep(32'h43, 1, 1);
      // half a period of offset moves the up-down wave to its top
      apb(1, `STRLFO_OFS_PHOFS, 32'h708);
      deep(32'h43, 0, 0);
      // a quarter period puts the wave near its midpoint, where the bend acts most
      apb(1, `STRLFO_OFS_PHOFS, 32'h384);
      apb(0, `STRLFO_OFS_STAT, 0);
      d1 = q;
      apb(1, `STRLFO_OFS_BEND, 32'hffffffc4);
      apb(0, `STRLFO_OFS_STAT, 0);
      `CHK(q[12:0] < d1[12:0], 1'b1)
      apb(1, `STRLFO_OFS_BEND, 32'h1e);
      apb(0, `STRLFO_OFS_STAT, 0);
      `CHK(q[12:0] > d1[12:0], 1'b1)
      apb(1, `STRLFO_OFS_BEND, 0);
      apb(1, `STRLFO_OFS_PHOFS, 0);
      for (int w = 0; w < 6; w++) begin
         apb(1, `STRLFO_OFS_CTRL, {25'h0, w[2:0], 4'h1});
         apb(0, `STRLFO_OFS_CTRL, 0);
         `CHK(q[6:4], w[2:0])
      end
      $display("test depth done");
   endtask
   task t_rate;
      apb(1, `STRLFO_OFS_RATE, 0);
      delta(d1);
      `CHK(d1, 32'h0)
      apb(1, `STRLFO_OFS_RATE, 32'h3e8);
      delta(d1);
      // ten hertz at 24000 pairs per second: four pairs step about 0x6d3a07
      `CHK(d1 >= 32'h6d3900 && d1 <= 32'h6d3b00, 1'b1)
      apb(1, `STRLFO_OFS_RATE, 32'h4b0);
      delta(d2);
      `CHK(d2, d1)
      apb(1, `STRLFO_OFS_MULT, 32'h2);
      delta(d2);
      `CHK(d2 + 32'h8 - 2 * d1 <= 32'h10, 1'b1)
      apb(1, `STRLFO_OFS_MULT, 32'h1);
      apb(1, `STRLFO_OFS_RATE, 32'h64);
      apb(1, `STRLFO_OFS_CTRL, 32'h43);
      apb(1, `STRLFO_OFS_TEMPO, 32'h3c);
      delta(d1);
      apb(1, `STRLFO_OFS_TEMPO, 32'h78);
      delta(d2);
      `CHK(d2 + 32'h8 - 2 * d1 <= 32'h10, 1'b1)
      apb(1, `STRLFO_OFS_CTRL, 32'h47);
      delta(d1);
      apb(1, `STRLFO_OFS_TEMPO, 32'hf0);
      delta(d2);
      `CHK(d2, d1)
      apb(1, `STRLFO_OFS_RATE, 0);
      delta(d1);
      `CHK(d1, 32'h0)
      $display("test rate done");
   endtask
   task results;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // main sequence after eight reset cycles
   initial begin
      repeat (8) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      t_regs;
      t_level;
      t_deep;
      t_rate;
      results;
   end
   // watchdog well beyond the several hundred cycles the tests need
   initial begin
      #100000;
      num_errors++;
      results;
   end
endmodule
